// File: src/dpw_wiper_ctrl.sv
// What this block does
// - First byte is address, six-bit prefix compared
// - Seventh address bit must equal select pin
// - Mismatched address ignores whole transaction
// - Last address bit: low write, high read
// - Eight-bit wiper decoded one-hot to 256 taps
// - Wiper starts at midscale after power-up
// - Write three bytes; a read resends the wiper byte for as long as the master acks
// - Second write byte is instruction, MSB ignored
// - Instruction bit 6 moves wiper to center
// - Bit 5 opens top, wiper shorted low
// - Shutdown keeps code; clearing restores stored tap
// - Writes during shutdown stored, used on exit
// - Third write byte stored unless bit 6 set, always acknowledged
// - Read: release line, no ack ends transmission
`timescale 1ns/10ps
`default_nettype none
`include "dpw_regs.svh"

module dpw_wiper_ctrl
	import dpw_pkg::*;
#(
	// Type prefix value is arbitrary, set per product
	parameter logic [5:0] TYPE_PREFIX = 6'h2A
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Serial bus, open drain data
	input wire logic scl,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	// Strap
	input wire logic addressSelectPin,
	// Resistor array control
	output logic [`DPW_TAP_COUNT-1:0] wiperTap,
	output logic topOpen,
	output logic [`DPW_WIPER_WIDTH-1:0] wiperCode
);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic addrMatch(input logic [7:0] addrByte,
		input logic sel);
		logic prefixOk;
		// Prefix and select bit must both match
		prefixOk = addrByte[`DPW_ADDR_PREFIX_MSB:`DPW_ADDR_PREFIX_LSB]
			== TYPE_PREFIX;
		return prefixOk && (addrByte[`DPW_ADDR_SEL_BIT] == sel);
	endfunction : addrMatch

	// ----------------------------------------------------------------
	// Line sampling
	// ----------------------------------------------------------------
	// Inputs already synchronous; one stage gives the previous value
	dpw_line_t curQ;
	dpw_line_t curD;
	dpw_line_t prevQ;
	dpw_line_t prevD;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;

	always_comb begin
		curD.scl = scl;
		curD.sda = sdaIn;
		prevD = curQ;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			curQ <= '{scl: 1'b1, sda: 1'b1};
			prevQ <= '{scl: 1'b1, sda: 1'b1};
		end else begin
			curQ <= curD;
			prevQ <= prevD;
		end
	end

	assign sclRise = curQ.scl && !prevQ.scl;
	assign sclFall = !curQ.scl && prevQ.scl;
	assign startSeen = curQ.scl && prevQ.scl && prevQ.sda && !curQ.sda;
	assign stopSeen = curQ.scl && prevQ.scl && !prevQ.sda && curQ.sda;

	// ----------------------------------------------------------------
	// Protocol and wiper register
	// ----------------------------------------------------------------
	dpw_proto_t pQ;
	dpw_proto_t pD;
	dpw_pot_t potQ;
	dpw_pot_t potD;
	logic byteFull;

	assign byteFull = (pQ.bitCnt == `DPW_BITS_PER_BYTE);

	// ----------------------------------------------------------------
	// Byte field decode
	// ----------------------------------------------------------------
	// Fields are read from the shift register at the fall after bit 8; the read/write bit at the fall after the ack
	logic addrOk;
	logic readReq;
	logic instrMid;
	logic instrShut;
	logic byteDone;
	logic msbPull;
	logic nextPull;

	assign addrOk = addrMatch(pQ.shift, addressSelectPin);
	assign readReq = pQ.shift[`DPW_ADDR_RW_BIT];
	assign instrMid = pQ.shift[`DPW_INSTR_MIDSCALE_BIT];
	assign instrShut = pQ.shift[`DPW_INSTR_SHUTDOWN_BIT];
	assign byteDone = sclFall && byteFull;
	// Open drain: a zero bit is sent by pulling the line
	assign msbPull = !potQ.wiper[7];
	assign nextPull = !pQ.shift[6];

	always_comb begin
		pD = pQ;
		potD = potQ;
		if (stopSeen) begin
			// A stop releases the line even mid-byte
			pD.state = ST_IDLE;
			pD.drive = 1'b0;
		end else if (startSeen) begin
			// A repeated start restarts the address phase
			pD.state = ST_ADDR;
			pD.bitCnt = 4'h0;
			pD.drive = 1'b0;
		end else begin
			unique case (pQ.state)
				ST_IDLE: begin
					pD.drive = 1'b0;
				end
				ST_WAIT: begin
					// Silent until the next stop or start
					pD.drive = 1'b0;
				end
				ST_ADDR: begin
					if (sclRise) begin
						pD.shift = {pQ.shift[6:0], curQ.sda};
						pD.bitCnt = pQ.bitCnt + 4'h1;
					end else if (byteDone) begin
						if (addrOk) begin
							pD.state = ST_ADDR_ACK;
							pD.drive = 1'b1;
						end else begin
							pD.state = ST_WAIT;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (sclFall) begin
						pD.bitCnt = 4'h0;
						pD.byteIdx = 1'b0;
						pD.holdMid = 1'b0;
						if (readReq) begin
							pD.state = ST_TX;
							pD.shift = potQ.wiper;
							pD.drive = msbPull;
						end else begin
							pD.state = ST_RX;
							pD.drive = 1'b0;
						end
					end
				end
				ST_RX: begin
					if (sclRise) begin
						pD.shift = {pQ.shift[6:0], curQ.sda};
						pD.bitCnt = pQ.bitCnt + 4'h1;
					end else if (byteDone) begin
						pD.state = ST_RX_ACK;
						pD.drive = 1'b1;
						if (!pQ.byteIdx) begin
							// Instruction byte, bit 7 unused
							// Midscale wins over the data byte that follows
							pD.holdMid = instrMid;
							potD.shutdown = instrShut;
							if (instrMid) begin
								potD.wiper = `DPW_MIDSCALE;
							end
						end else if (!pQ.holdMid) begin
							// Stored even in shutdown
							potD.wiper = pQ.shift;
						end
					end
				end
				ST_RX_ACK: begin
					if (sclFall) begin
						pD.drive = 1'b0;
						pD.bitCnt = 4'h0;
						if (pQ.byteIdx) begin
							// Third byte ends a write
							pD.state = ST_WAIT;
						end else begin
							pD.state = ST_RX;
							pD.byteIdx = 1'b1;
						end
					end
				end
				ST_TX: begin
					if (sclRise) begin
						pD.bitCnt = pQ.bitCnt + 4'h1;
					end else if (sclFall) begin
						if (byteFull) begin
							pD.state = ST_TX_ACK;
							pD.drive = 1'b0;
						end else begin
							pD.shift = {pQ.shift[6:0], 1'b0};
							pD.drive = nextPull;
						end
					end
				end
				ST_TX_ACK: begin
					if (sclRise) begin
						// Sampled on the rise, acted on at the fall
						pD.masterAck = !curQ.sda;
					end else if (sclFall) begin
						pD.bitCnt = 4'h0;
						if (pQ.masterAck) begin
							pD.state = ST_TX;
							pD.shift = potQ.wiper;
							pD.drive = msbPull;
						end else begin
							pD.state = ST_WAIT;
						end
					end
				end
				default: begin
					pD.state = ST_IDLE;
					pD.drive = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pQ <= '{
				state: ST_IDLE,
				bitCnt: 4'h0,
				shift: 8'h00,
				byteIdx: 1'b0,
				holdMid: 1'b0,
				drive: 1'b0,
				masterAck: 1'b0
			};
			potQ <= '{wiper: `DPW_MIDSCALE, shutdown: 1'b0};
		end else begin
			pQ <= pD;
			potQ <= potD;
		end
	end

	// ----------------------------------------------------------------
	// Tap decode
	// ----------------------------------------------------------------
	// Registered so the switch array never sees decode glitches
	logic [`DPW_TAP_COUNT-1:0] tapD;
	logic [`DPW_TAP_COUNT-1:0] tapQ;
	logic topOpenD;
	logic topOpenQ;

	genvar i;
	generate
		for (i = 0; i < `DPW_TAP_COUNT; i++) begin : g_tap
			// Shutdown selects tap 0 but keeps the code
			always_comb begin
				if (potQ.shutdown) begin
					tapD[i] = (i == 0);
				end else begin
					tapD[i] = (potQ.wiper == 8'(i));
				end
			end
		end
	endgenerate

	assign topOpenD = potQ.shutdown;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			// Same tap as the reset code, so no glitch at release
			tapQ <= `DPW_TAP_COUNT'(1) << `DPW_MIDSCALE;
			topOpenQ <= 1'b0;
		end else begin
			tapQ <= tapD;
			topOpenQ <= topOpenD;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Only ever pulls low; the bus pull-up gives the high
	assign sdaOut = 1'b0;
	assign sdaOe = pQ.drive;
	assign wiperTap = tapQ;
	assign topOpen = topOpenQ;
	assign wiperCode = potQ.wiper;

endmodule : dpw_wiper_ctrl

`default_nettype wire

// File: src/dpw_regs.svh
`ifndef DPW_REGS_SVH
`define DPW_REGS_SVH

// ----------------------------------------------------------------
// Wiper register
// ----------------------------------------------------------------
`define DPW_WIPER_WIDTH 8
`define DPW_TAP_COUNT 256
`define DPW_MIDSCALE 8'h80

// ----------------------------------------------------------------
// Address byte fields
// ----------------------------------------------------------------
`define DPW_ADDR_PREFIX_MSB 7
`define DPW_ADDR_PREFIX_LSB 2
`define DPW_ADDR_SEL_BIT 1
`define DPW_ADDR_RW_BIT 0

// ----------------------------------------------------------------
// Instruction byte fields
// ----------------------------------------------------------------
`define DPW_INSTR_MIDSCALE_BIT 6
`define DPW_INSTR_SHUTDOWN_BIT 5

// ----------------------------------------------------------------
// Bit counting
// ----------------------------------------------------------------
`define DPW_BITS_PER_BYTE 4'h8

`endif

// File: src/dpw_pkg.sv
`default_nettype none
package dpw_pkg;

	// ----------------------------------------------------------------
	// Protocol states, Gray along address/rx/tx path
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_ADDR_ACK = 4'h3,
		ST_RX = 4'h2,
		ST_RX_ACK = 4'h6,
		ST_TX = 4'h7,
		ST_TX_ACK = 4'h5,
		ST_WAIT = 4'h4
	} dpw_state_t;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic scl;
		logic sda;
	} dpw_line_t;

	typedef struct packed {
		logic [7:0] wiper;
		logic shutdown;
	} dpw_pot_t;

	typedef struct packed {
		dpw_state_t state;
		logic [3:0] bitCnt;
		logic [7:0] shift;
		logic byteIdx;
		logic holdMid;
		logic drive;
		logic masterAck;
	} dpw_proto_t;

endpackage : dpw_pkg
`default_nettype wire

// File: tb/dpw_bus_master.sv
`timescale 1ns/10ps
`default_nettype none
module dpw_bus_master (
	// Clock and device drive
	input wire logic mclk,
	input wire logic sdaOe,
	input wire logic sdaOut,
	// Bus lines
	output logic scl,
	output logic sdaIn
);
	logic drv = 1'b1;
	initial scl = 1'b1;
	// Pull-up: a released line reads high
	assign sdaIn = drv & (sdaOe ? sdaOut : 1'b1);
	task automatic hp(input logic c, d);
		@(posedge mclk);
		scl <= c;
		drv <= d;
		repeat (4) @(posedge mclk);
	endtask : hp
	task automatic start();
		hp(1'b1, 1'b1);
		hp(1'b1, 1'b0);
	endtask : start
	task automatic stop();
		hp(1'b0, 1'b0);
		hp(1'b1, 1'b0);
		hp(1'b1, 1'b1);
	endtask : stop
	// Bit 0 is the ack slot
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			hp(1'b0, drv);
			hp(1'b0, tx[i]);
			hp(1'b1, tx[i]);
			rx[i] = sdaIn;
		end
	endtask : xfer
endmodule : dpw_bus_master
`default_nettype wire

// File: tb/dpw_wiper_ctrl_properties.sv
`timescale 1ns/10ps
`default_nettype none
module dpw_props (
	// Clock, reset and bus
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sdaOut,
	input wire logic sdaOe,
	// Resistor array
	input wire logic [255:0] wiperTap,
	input wire logic topOpen,
	input wire logic [7:0] wiperCode
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence shutHeld;
		topOpen ##1 topOpen;
	endsequence
	tap_decode_a: assert property (
		!topOpen && $stable({topOpen, wiperCode}) |->
		wiperTap == 256'h1 << wiperCode) else $error("tap");
	shut_tap_a: assert property (
		shutHeld |-> wiperTap == 256'h1) else $error("shut tap");
	reset_mid_a: assert property (
		$rose(rst_n) |-> wiperCode == 8'h80 && !topOpen) else $error("mid");
	code_low_a: assert property (
		$changed(wiperCode) |-> !scl) else $error("code");
	oe_low_a: assert property (
		$changed(sdaOe) |-> !scl) else $error("oe");
	shut_low_a: assert property (
		$changed(topOpen) |-> !scl) else $error("shut edge");
	shut_keep_a: assert property (
		$rose(topOpen) && wiperCode != 8'h80 |-> $stable(wiperCode))
		else $error("keep");
	sda_drain_a: assert property (
		sdaOut == 1'b0) else $error("sda");
endmodule : dpw_props
bind dpw_wiper_ctrl dpw_props i_props (.mclk(mclk), .rst_n(rst_n),
	.scl(scl), .sdaOut(sdaOut), .sdaOe(sdaOe), .wiperTap(wiperTap),
	.topOpen(topOpen), .wiperCode(wiperCode));
`default_nettype wire

// File: tb/test_dpw_wiper_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module test_dpw_wiper_ctrl;
	logic mclk = 1'b0, rst_n = 1'b0, sel = 1'b1;
	logic scl, sdaIn, sdaOe, sdaOut, topOpen;
	logic [255:0] tap;
	logic [7:0] code;
	int errCount = 0, nChecks = 0;
	always #12.5 mclk = ~mclk;
	dpw_bus_master i_mst (.mclk(mclk), .sdaOe(sdaOe), .sdaOut(sdaOut),
		.scl(scl), .sdaIn(sdaIn));
	dpw_wiper_ctrl i_dut (.mclk(mclk), .rst_n(rst_n), .scl(scl),
		.sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.addressSelectPin(sel),
		.wiperTap(tap), .topOpen(topOpen), .wiperCode(code));
	task automatic chk(input string n, input logic [255:0] s, e);
		nChecks++;
		if (s !== e) begin
			errCount++;
			$display("[ERR] %s exp %0h seen %0h", n, e, s);
		end
	endtask : chk
	task automatic pot(input logic [7:0] c, input logic shut);
		chk("code", code, c);
		chk("shut", topOpen, shut);
		chk("tap", tap, shut ? 256'h1 : 256'h1 << c);
	endtask : pot
	task automatic wr(input logic [23:0] b, input logic [2:0] na);
		logic [8:0] r;
		i_mst.start();
		for (int k = 2; k >= 0; k--) begin
			i_mst.xfer({b[k*8+:8], 1'b1}, r);
			chk("ack", r[0], na[k]);
		end
		i_mst.stop();
	endtask : wr
	task automatic t_rw();
		logic [8:0] r;
		pot(8'h80, 1'b0);
		wr(24'hAA803C, 3'h0);
		i_mst.start();
		i_mst.xfer(9'h157, r);
		chk("rack", r[0], 1'b0);
		i_mst.xfer(9'h1FE, r);
		chk("rd", r[8:1], 8'h3C);
		i_mst.xfer(9'h1FF, r);
		chk("rd", r[8:1], 8'h3C);
		i_mst.xfer(9'h1FF, r);
		chk("rd", r[8:1], 8'hFF);
		i_mst.stop();
	endtask : t_rw
	task automatic t_addr();
		wr(24'hA80011, 3'h7);
		wr(24'h2A0011, 3'h7);
		chk("code", code, 8'h3C);
		sel <= 1'b0;
		wr(24'hA8005A, 3'h0);
		pot(8'h5A, 1'b0);
		sel <= 1'b1;
	endtask : t_addr
	task automatic t_shut();
		wr(24'hAA2011, 3'h0);
		pot(8'h11, 1'b1);
		wr(24'hAA2022, 3'h0);
		pot(8'h22, 1'b1);
		wr(24'hAA0022, 3'h0);
		pot(8'h22, 1'b0);
		wr(24'hAAC007, 3'h0);
		pot(8'h80, 1'b0);
	endtask : t_shut
	task automatic final_report();
		$display("checks %0d errors %0d", nChecks, errCount);
		if (errCount == 0 && nChecks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report
	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		t_rw();
		t_addr();
		t_shut();
		final_report();
	end
	// The 28 byte transfers with their starts and stops take about 4000 cycles
	initial begin
		repeat (20000) @(posedge mclk);
		errCount++;
		final_report();
	end
endmodule : test_dpw_wiper_ctrl
`default_nettype wire
